// [verilog/lhp_regs.svh]
// Constants of the display controller host port: decode codes, field positions, timing.
// Assumes a 100 MHz system clock; included by the host port design file only.
// Summary of operation
// (R1) Four host link types exist: two-wire serial, four-wire serial, 4-bit and 8-bit parallel. Only parallel is built; serial strobes are ignored.
// (R2) Two link select pins choose serial or parallel operation.
// (R3) In parallel mode the bus width bit chooses 4-bit or 8-bit transfers.
// (R4) Two 8-bit host registers exist: command holding and data holding.
// (R5) Data holding register stages bytes for text RAM or glyph RAM, last address command decides.
// (R6) After a data read the next RAM byte is loaded automatically.
// (R7) After a data write the byte goes to the selected RAM automatically.
// (R8) Command register is write only; no path reads it back.
// (R9) Select/direction: 00 command write, 01 status read, 10 data write, 11 data read.
// (R10) Each data access steps the RAM pointer by one, up or down.
// (R11) Busy flag stays high during internal work; commands are then refused. The port queues them in the FIFO instead and runs them afterwards.
// (R12) Host keeps the link select pins stable while the device runs. The bench switches linkSelectHigh from serial to parallel after reset.
`ifndef LHP_REGS_SVH
`define LHP_REGS_SVH
`define LHP_CLK_MHZ       100
`define LHP_OP_TIME_NS    18500
`define LHP_OP_CYCLES     ((`LHP_OP_TIME_NS * `LHP_CLK_MHZ + 999) / 1000)
`define LHP_LONG_TIME_NS  760000
`define LHP_LONG_CYCLES   ((`LHP_LONG_TIME_NS * `LHP_CLK_MHZ + 999) / 1000)
`define LHP_CMD_CLEAR     8'h01
`define LHP_BIT_HOME      1
`define LHP_BIT_ENTRY     2
`define LHP_BIT_FUNC      5
`define LHP_BIT_GLYPH     6
`define LHP_BIT_TEXT      7
`define LHP_POS_DIR       1
`define LHP_POS_WIDTH     4
`define LHP_BLANK_CHAR    8'h20
`define LHP_TEXT_DEPTH    128
`define LHP_GLYPH_DEPTH   64
`define LHP_FIFO_DEPTH    16
`endif

// [verilog/lhp_pkg.sv]
// Types shared by the host port design files.
// Assumes lhp_regs.svh is on the include path.
package lhp_pkg;
    typedef enum logic [1:0] {
        LHP_LINK_TWO_WIRE,
        LHP_LINK_FOUR_WIRE,
        LHP_LINK_PAR
    } lhp_link_t;
    typedef struct packed {
        logic       isData;
        logic [7:0] value;
    } lhp_word_t;
endpackage : lhp_pkg

// [verilog/lhp_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module lhp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             doPush;
    logic             doPop;
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = store[rdPtr];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;
    always_ff @(posedge clk) begin
        if (doPush) begin
            store[wrPtr] <= inData;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule : lhp_fifo

// [verilog/lhp_host_port.sv]
// Parallel host port: pin sync, nibble pairing, command decode, RAM staging.
// Assumes bus pins arrive asynchronously and the strobe is an active-high enable.
`timescale 1ns/100ps
`include "lhp_regs.svh"
module lhp_host_port (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       linkSelectHigh,
    input  wire logic       linkSelectLow,
    input  wire logic       registerSelectLine,
    input  wire logic       readNotWrite,
    input  wire logic       enableStrobe,
    input  wire logic [7:0] busIn,
    output logic      [7:0] busOut,
    output logic            busOe,
    output logic            operationPendingFlag,
    output logic            wideBus,
    output logic            parallelMode,
    output logic            hostStall
);
    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    logic [11:0] syncA;
    logic [11:0] syncB;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA      <= 12'h000;
            syncB      <= 12'h000;
        end else begin
            syncA      <= {linkSelectHigh, linkSelectLow, registerSelectLine,
                           readNotWrite, busIn};
            syncB      <= syncA;
        end
    end
    logic       selHi;
    logic       selLo;
    logic       selData;
    logic       dirRead;
    logic [7:0] pinData;
    assign {selHi, selLo, selData, dirRead, pinData} = syncB;
    logic enA;
    logic enB;
    logic enPrev;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enA    <= 1'b0;
            enB    <= 1'b0;
            enPrev <= 1'b0;
        end else begin
            enA    <= enableStrobe;
            enB    <= enA;
            enPrev <= enB;
        end
    end
    logic strobeFall;
    assign strobeFall = enPrev && !enB;
    // ****************************************************************
    // Link type and width.
    // ****************************************************************
    lhp_pkg::lhp_link_t linkType;
    logic               isParallel;
    always_comb begin
        case ({selHi, selLo})
            2'b00:   linkType = lhp_pkg::LHP_LINK_TWO_WIRE; // R1 R2
            2'b01:   linkType = lhp_pkg::LHP_LINK_FOUR_WIRE; // R1 R2
            default: linkType = lhp_pkg::LHP_LINK_PAR; // R1 R2
        endcase
    end
    // Serial links are not built here; strobes on them are ignored.
    assign isParallel = (linkType == lhp_pkg::LHP_LINK_PAR);
    logic bus_width_bit;
    logic highNibbleDone;
    logic [3:0] highNibble;
    logic       fullByte;
    logic [7:0] hostByte;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            highNibbleDone <= 1'b0;
            highNibble     <= 4'h0;
        end else if (strobeFall && isParallel && !bus_width_bit) begin // R3
            highNibbleDone <= !highNibbleDone;
            highNibble     <= pinData[7:4];
        end
    end
    assign fullByte = strobeFall && isParallel && (bus_width_bit || highNibbleDone); // R3
    assign hostByte = bus_width_bit ? pinData : {highNibble, pinData[7:4]};
    // ****************************************************************
    // Host writes enter a FIFO so the host may burst while work runs.
    // ****************************************************************
    logic             pushValid;
    logic             pushReady;
    lhp_pkg::lhp_word_t pushWord;
    lhp_pkg::lhp_word_t popWord;
    logic             popValid;
    logic             popReady;
    assign pushValid = fullByte && !dirRead;
    assign pushWord  = '{isData: selData, value: hostByte};
    lhp_fifo #(.WIDTH(9), .DEPTH(`LHP_FIFO_DEPTH)) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inData   (pushWord),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .outData  (popWord),
        .outValid (popValid),
        .outReady (popReady)
    );
    // ****************************************************************
    // Engine: command execution and RAM transfers.
    // ****************************************************************
    typedef enum logic [1:0] {
        LHP_IDLE,
        LHP_WORK,
        LHP_CLEAR
    } lhp_state_t;
    lhp_state_t state;
    logic [7:0]  command_holding_reg;
    logic [7:0]  data_holding_reg;
    logic [6:0]  ram_pointer;
    logic        glyphTarget;
    logic        stepDown;
    logic [19:0] waitCount;
    logic [7:0]  textRam  [`LHP_TEXT_DEPTH];
    logic [7:0]  glyphRam [`LHP_GLYPH_DEPTH];
    logic        readReq;
    logic        takeWord;
    logic [6:0]  stepped;
    assign readReq  = fullByte && dirRead && selData;
    assign takeWord = popValid && (state == LHP_IDLE) && !readReq;
    assign popReady = takeWord;
    assign stepped  = stepDown ? ram_pointer - 7'h01 : ram_pointer + 7'h01; // R10
    always_ff @(posedge clk) begin
        if (takeWord && popWord.isData) begin
            if (glyphTarget) begin
                glyphRam[ram_pointer[5:0]] <= popWord.value; // R5 R7
            end else begin
                textRam[ram_pointer] <= popWord.value; // R5 R7
            end
        end else if (state == LHP_CLEAR) begin
            textRam[waitCount[6:0]] <= `LHP_BLANK_CHAR;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state               <= LHP_IDLE;
            command_holding_reg <= 8'h00;
            data_holding_reg    <= 8'h00;
            ram_pointer         <= 7'h00;
            glyphTarget         <= 1'b0;
            stepDown            <= 1'b0;
            bus_width_bit       <= 1'b1;
            waitCount           <= 20'h00000;
        end else begin
            case (state)
                LHP_IDLE: begin
                    if (readReq) begin
                        // The staged byte was just driven; refill from the next address.
                        ram_pointer      <= stepped; // R6 R10
                        data_holding_reg <= glyphTarget ? glyphRam[stepped[5:0]]
                                                        : textRam[stepped]; // R6
                    end else if (takeWord && popWord.isData) begin
                        ram_pointer <= stepped; // R10
                        state       <= LHP_WORK;
                        waitCount   <= 20'(`LHP_OP_CYCLES);
                    end else if (takeWord) begin
                        command_holding_reg <= popWord.value; // R4 R8
                        state               <= LHP_WORK;
                        waitCount           <= 20'(`LHP_OP_CYCLES);
                        if (popWord.value[`LHP_BIT_TEXT]) begin
                            glyphTarget <= 1'b0; // R5
                            ram_pointer <= popWord.value[6:0];
                        end else if (popWord.value[`LHP_BIT_GLYPH]) begin
                            glyphTarget <= 1'b1; // R5
                            ram_pointer <= {1'b0, popWord.value[5:0]};
                        end else if (popWord.value[`LHP_BIT_FUNC]) begin
                            bus_width_bit <= popWord.value[`LHP_POS_WIDTH]; // R3
                        // Display and shift codes also set bit 2 or bit 1, so those
                        // bits alone do not name entry mode or home.
                        end else if (popWord.value[`LHP_BIT_ENTRY]
                                     && popWord.value[4:3] == 2'b00) begin
                            stepDown <= !popWord.value[`LHP_POS_DIR]; // R10
                        end else if (popWord.value == `LHP_CMD_CLEAR) begin
                            glyphTarget <= 1'b0;
                            ram_pointer <= 7'h00;
                            state       <= LHP_CLEAR;
                            waitCount   <= 20'h00000;
                        end else if (popWord.value[`LHP_BIT_HOME]
                                     && popWord.value[4:2] == 3'b000) begin
                            glyphTarget <= 1'b0;
                            ram_pointer <= 7'h00;
                            waitCount   <= 20'(`LHP_LONG_CYCLES);
                        end
                    end
                end
                LHP_WORK: begin
                    // Refresh the staged byte so a later read sees current RAM content.
                    data_holding_reg <= glyphTarget ? glyphRam[ram_pointer[5:0]]
                                                    : textRam[ram_pointer];
                    waitCount <= waitCount - 20'h00001;
                    if (waitCount <= 20'h00001) begin
                        state <= LHP_IDLE;
                    end
                end
                LHP_CLEAR: begin
                    waitCount <= waitCount + 20'h00001;
                    if (waitCount[6:0] == 7'h7F) begin
                        state     <= LHP_WORK;
                        waitCount <= 20'(`LHP_LONG_CYCLES);
                    end
                end
                default: state <= LHP_IDLE;
            endcase
        end
    end
    // ****************************************************************
    // Read path and status outputs.
    // ****************************************************************
    logic       busy;
    logic [7:0] readByte;
    assign busy     = (state != LHP_IDLE) || popValid; // R11
    // The command byte has no read path; the status read shows flag and pointer.
    assign readByte = selData ? data_holding_reg : {busy, ram_pointer}; // R8 R9
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busOut               <= 8'h00;
            busOe                <= 1'b0;
            operationPendingFlag <= 1'b0;
            wideBus              <= 1'b1;
            parallelMode         <= 1'b0;
            hostStall            <= 1'b0;
        end else begin
            busOe                <= enB && dirRead && isParallel; // R9
            busOut               <= (bus_width_bit || !highNibbleDone) ? readByte
                                    : {readByte[3:0], 4'h0};
            operationPendingFlag <= busy; // R11
            wideBus              <= bus_width_bit;
            parallelMode         <= isParallel;
            hostStall            <= !pushReady;
        end
    end
    chk_busy_refuse: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (state != LHP_IDLE) |=> $stable(command_holding_reg))
        else $error("Command taken while busy.");
    chk_busy_flag: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (state != LHP_IDLE) |=> operationPendingFlag)
        else $error("Busy flag low during work.");
    chk_write_step: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (takeWord && popWord.isData && !stepDown) |=> ram_pointer == $past(ram_pointer) + 7'h01)
        else $error("Pointer not stepped after write.");
    chk_read_step: assert property (@(posedge clk) disable iff (!rst_n) // R6
        (readReq && stepDown) |=> ram_pointer == $past(ram_pointer) - 7'h01)
        else $error("Pointer not stepped down after read.");
    chk_text_select: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (takeWord && !popWord.isData && popWord.value[7]) |=> !glyphTarget)
        else $error("Text address did not select text RAM.");
    chk_width_set: assert property (@(posedge clk) disable iff (!rst_n) // R3
        (takeWord && !popWord.isData && popWord.value[7:5] == 3'b001)
        |=> bus_width_bit == $past(popWord.value[4]))
        else $error("Width bit not taken.");
    chk_bus_oe: assert property (@(posedge clk) disable iff (!rst_n) // R9
        busOe |-> $past(dirRead))
        else $error("Bus driven on a write.");
    chk_wide_out: assert property (@(posedge clk) disable iff (!rst_n) // R3
        ##1 wideBus == $past(bus_width_bit))
        else $error("Width output stale.");
endmodule : lhp_host_port

// [tb/lhp_host_model.sv]
// Host processor model that drives the parallel pins of the display host port.
// Assumes the bench calls xfer and that busOut is driven while busOe is high.
`timescale 1ns/100ps
module lhp_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] busOut,
    input  wire logic       busOe,
    output logic            registerSelectLine,
    output logic            readNotWrite,
    output logic            enableStrobe,
    output logic      [7:0] busIn,
    output logic            rdValid,
    output logic      [7:0] rdByte
);
    logic fourBit = 1'b0;
    initial begin
        registerSelectLine = 1'b0;
        readNotWrite = 1'b0;
        enableStrobe = 1'b0;
        busIn = 8'h00;
        rdValid = 1'b0;
        rdByte = 8'h00;
    end
    // One strobe; pins are held until well after the falling edge that the port takes.
    task automatic pulse(input logic rs, input logic rnw, input logic [7:0] wd,
                         output logic [7:0] rd);
        @(negedge clk);
        registerSelectLine = rs;
        readNotWrite = rnw;
        busIn = rnw ? ~busIn : wd;
        repeat (2) @(negedge clk);
        enableStrobe = 1'b1;
        // Sample at the falling edge, away from the edge that updates the port's outputs.
        repeat (6) @(negedge clk);
        // An undriven bus reads back inverted, so a read without the port's enable fails.
        rd = busOe ? busOut : ~busOut;
        enableStrobe = 1'b0;
        repeat (6) @(negedge clk);
        // A released bus must not keep showing the last value.
        busIn = ~busIn;
    endtask : pulse
    task automatic xfer(input logic rs, input logic rnw, input logic report,
                        input logic [7:0] wd, output logic [7:0] rd);
        logic [7:0] hi;
        logic [7:0] lo;
        if (fourBit) begin
            pulse(rs, rnw, {wd[7:4], 4'h0}, hi);
            pulse(rs, rnw, {wd[3:0], 4'h0}, lo);
            rd = {hi[7:4], lo[7:4]};
        end else begin
            pulse(rs, rnw, wd, rd);
        end
        if (report) begin
            rdByte = rd;
            rdValid = 1'b1;
            @(negedge clk);
            rdValid = 1'b0;
        end
    endtask : xfer
endmodule : lhp_host_model

// [tb/tb.sv]
// Self-checking bench for the display host port with a host model on its pins.
// Assumes the design files and lhp_regs.svh are compiled first.
`timescale 1ns/100ps
`define CHECK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb;
    logic clk = 1'b0, rst_n = 1'b0, linkSelectHigh = 1'b0, linkSelectLow = 1'b0;
    logic rsLine, rnwLine, strobe, rdValid, busOe, pending, wideBus, parMode, stall;
    logic [7:0] busIn, busOut, rdByte, rd, expByte;
    logic [7:0] d [4];
    logic [7:0] expQ [$];
    int errors = 0, comparisons = 0, cycles = 0, k;
    logic [31:0] seed = 32'h13E8BCBB;
    initial forever #5 clk = ~clk;
    lhp_host_port dut (.clk(clk), .rst_n(rst_n), .linkSelectHigh(linkSelectHigh),
        .linkSelectLow(linkSelectLow), .registerSelectLine(rsLine), .readNotWrite(rnwLine),
        .enableStrobe(strobe), .busIn(busIn), .busOut(busOut), .busOe(busOe),
        .operationPendingFlag(pending), .wideBus(wideBus), .parallelMode(parMode),
        .hostStall(stall));
    lhp_host_model host (.clk(clk), .busOut(busOut), .busOe(busOe), .registerSelectLine(rsLine),
        .readNotWrite(rnwLine), .enableStrobe(strobe), .busIn(busIn), .rdValid(rdValid),
        .rdByte(rdByte));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            errors++;
            tally_and_finish();
        end
    end
    // The note is popped once so that a mismatch prints the value compared.
    always @(posedge clk) begin
        if (rdValid) begin
            expByte = expQ.pop_front();
            `CHECK("read byte", expByte, rdByte)
        end
    end
    // Polling status keeps the host honest: no command while the flag is high.
    task automatic wait_idle();
        for (k = 0; k < 300; k++) begin
            host.xfer(1'b0, 1'b1, 1'b0, 8'h00, rd);
            if (rd[7] === 1'b0) break;
        end
        `CHECK("idle poll", 1'b0, rd[7])
    endtask : wait_idle
    task automatic cmd(input logic [7:0] c);
        host.xfer(1'b0, 1'b0, 1'b0, c, rd);
        repeat (4) @(negedge clk);
        `CHECK("busy flag", 1'b1, pending)
        wait_idle();
    endtask : cmd
    task automatic wr(input logic [7:0] v);
        host.xfer(1'b1, 1'b0, 1'b0, v, rd);
        wait_idle();
    endtask : wr
    task automatic rd_exp(input logic rs, input logic [7:0] v);
        expQ.push_back(v);
        host.xfer(rs, 1'b1, 1'b1, 8'h00, rd);
        wait_idle();
    endtask : rd_exp
    initial begin
        repeat (20) @(negedge clk);
        `CHECK("reset width", 1'b1, wideBus)
        `CHECK("reset flag", 1'b0, pending)
        `CHECK("reset stall", 1'b0, stall)
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        `CHECK("serial mode", 1'b0, parMode)
        host.xfer(1'b0, 1'b0, 1'b0, 8'h01, rd);
        repeat (10) @(negedge clk);
        `CHECK("serial ignored", 1'b0, pending)
        linkSelectHigh = 1'b1;
        repeat (5) @(negedge clk);
        `CHECK("parallel mode", 1'b1, parMode)
        cmd(8'h06);
        cmd(8'h90);
        foreach (d[i]) begin
            d[i] = rnd();
            wr(d[i]);
        end
        rd_exp(1'b0, 8'h14);
        cmd(8'h90);
        rd_exp(1'b1, d[0]);
        rd_exp(1'b1, d[1]);
        rd_exp(1'b1, d[2]);
        rd_exp(1'b0, 8'h13);
        cmd(8'h04);
        cmd(8'hA0);
        d[0] = rnd();
        wr(d[0]);
        rd_exp(1'b0, 8'h1F);
        cmd(8'hA0);
        rd_exp(1'b1, d[0]);
        rd_exp(1'b0, 8'h1F);
        cmd(8'h06);
        cmd(8'h0C);
        cmd(8'h43);
        wr(8'h1B);
        wr(8'h0E);
        rd_exp(1'b0, 8'h05);
        cmd(8'h43);
        rd_exp(1'b1, 8'h1B);
        rd_exp(1'b1, 8'h0E);
        host.xfer(1'b0, 1'b0, 1'b0, 8'h20, rd);
        // The host narrows its own bus before polling, as the port is already 4-bit.
        host.fourBit = 1'b1;
        wait_idle();
        `CHECK("narrow bus", 1'b0, wideBus)
        cmd(8'hB0);
        d[3] = rnd();
        wr(d[3]);
        rd_exp(1'b0, 8'h31);
        cmd(8'hB0);
        rd_exp(1'b1, d[3]);
        host.xfer(1'b0, 1'b0, 1'b0, 8'h30, rd);
        host.fourBit = 1'b0;
        wait_idle();
        `CHECK("wide bus", 1'b1, wideBus)
        cmd(8'hC0);
        for (k = 0; k < 24 && stall !== 1'b1; k++) host.xfer(1'b1, 1'b0, 1'b0, rnd(), rd);
        `CHECK("fifo full", 1'b1, stall)
        for (k = 0; k < 40000 && pending !== 1'b0; k++) @(negedge clk);
        `CHECK("drained", 1'b0, pending)
        tally_and_finish();
    end
endmodule : tb
